// ---- rtl/stsr_pkg.sv ----
`default_nettype none
// ********************************
// self-timed sram shared constants
// ********************************
package stsr_pkg;
  // array shape, fixed
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int DEPTH  = 16;

  // timing: access time in ns, rounded up to whole cycles
  localparam int CLK_NS     = 20;
  localparam int ACCESS_NS  = 35;
  localparam int ACC_CYC    = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  // delay-line stages after the operation edge; must stay >= 1
  localparam int ACC_STAGES = ACC_CYC - 1;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_DOUT = 8'h08;

  // field positions
  localparam int CTRL_ADV_BIT  = 0;
  localparam int CTRL_PAR_BIT  = 1;
  localparam int STAT_OE_BIT   = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_PERR_BIT = 2;

  // reset values
  localparam logic CTRL_ADV_RST = 1'b1;
  localparam logic CTRL_PAR_RST = 1'b0;

  // kind of captured memory cycle
  typedef enum logic [2:0] {
    OP_IDLE,
    OP_READ,
    OP_DESEL,
    OP_WRITE,
    OP_WSKIP
  } stsr_op_t;

  // even parity of a data word
  function automatic logic stsr_par(input logic [DATA_W-1:0] w);
    stsr_par = ^w;
  endfunction
endpackage
`default_nettype wire

// ---- rtl/stsr_tgen.sv ----
`timescale 1ns/1ps
`default_nettype none
// ********************************
// output register timing generator
// ********************************
module stsr_tgen
  import stsr_pkg::*;
(
  // clock, reset and clock enable
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              ce,
  // launch side
  input  wire logic              in_vld,
  input  wire logic              in_rd,
  input  wire logic [ADDR_W-1:0] in_addr,
  // load strobe side
  output logic                   out_vld,
  output logic                   out_rd,
  output logic [ADDR_W-1:0]      out_addr,
  output logic                   busy
);
  logic              vld_q  [ACC_STAGES]; // stage holds a load
  logic              vld_d  [ACC_STAGES];
  logic              rd_q   [ACC_STAGES]; // 1 read, 0 deselect
  logic              rd_d   [ACC_STAGES];
  logic [ADDR_W-1:0] adr_q  [ACC_STAGES]; // word to fetch
  logic [ADDR_W-1:0] adr_d  [ACC_STAGES];

  // delay line: one entry per cycle so back-to-back reads pipeline
  always_comb
  begin
    // stage 0 takes the launch; no index below zero is ever formed
    vld_d[0] = in_vld;
    rd_d[0]  = in_rd;
    adr_d[0] = in_addr;
    busy     = vld_q[0];
    for (int i = 1; i < ACC_STAGES; i++)
    begin
      vld_d[i] = vld_q[i-1];
      rd_d[i]  = rd_q[i-1];
      adr_d[i] = adr_q[i-1];
      busy     = busy | vld_q[i];
    end
    out_vld  = vld_q[ACC_STAGES-1];
    out_rd   = rd_q[ACC_STAGES-1];
    out_addr = adr_q[ACC_STAGES-1];
  end

  // registers advance only while the clock enable is high
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < ACC_STAGES; i++)
      begin
        vld_q[i] <= 1'b0;
        rd_q[i]  <= 1'b0;
        adr_q[i] <= '0;
      end
    end
    else if (ce)
    begin
      vld_q <= vld_d;
      rd_q  <= rd_d;
      adr_q <= adr_d;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/stsr_core.sv ----
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - capture all inputs on the clock edge
// - write pulse generated inside, none external
// - basic mode: read out at next capture
// - advanced mode: timing generator loads output
// - advanced load does not wait for capture
// - write cycles leave outputs unchanged
// - hold input makes a cycle do nothing
// - hold acts as enable, no clock slivers
// - outputs keep last read word
// - unselected read disables the outputs
// - unselected write never disables outputs
// - parity check never disturbs normal operation
module stsr_core
  import stsr_pkg::*;
(
  // clock, reset, global enable
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              ce,
  // ahb-lite register slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // memory port from pipeline logic
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic [DATA_W-1:0] mem_wdata,
  input  wire logic              mem_we,
  input  wire logic              mem_sel,
  input  wire logic              mem_hold,
  // bussed data output
  output logic [DATA_W-1:0]      mem_dout,
  output logic                   mem_dout_oe
);
  // ********************************
  // state
  // ********************************
  stsr_op_t          cap_op_q, cap_op_d;     // captured cycle kind
  logic [ADDR_W-1:0] cap_addr_q, cap_addr_d; // captured address
  logic [DATA_W-1:0] cap_wd_q, cap_wd_d;     // captured write data
  logic [DATA_W-1:0] mem_q [DEPTH];          // storage array
  logic [DATA_W-1:0] mem_d [DEPTH];
  logic              par_q [DEPTH];          // stored parity bits
  logic              par_d [DEPTH];
  logic [DATA_W-1:0] dout_q, dout_d;         // output register
  logic              oe_q, oe_d;             // output enable
  logic              adv_q, adv_d;           // advanced timing mode
  logic              pen_q, pen_d;           // parity check enable
  logic              perr_q, perr_d;         // sticky parity error
  logic              wpend_q, wpend_d;       // bus write data phase due
  logic [7:0]        wofs_q, wofs_d;         // its register offset
  logic [31:0]       hrdata_q, hrdata_d;
  logic              hready_q;

  // combinational helpers
  logic              fire;      // captured cycle executes at this edge
  logic              b_ld;      // basic-mode output load
  logic              tg_in;     // launch into timing generator
  logic              tg_vld, tg_rd, tg_busy;
  logic [ADDR_W-1:0] tg_addr;
  logic              ld_vld, ld_rd;
  logic [ADDR_W-1:0] ld_addr;
  logic [DATA_W-1:0] rd_word;   // array word being loaded
  logic              ap_take;   // bus address phase taken
  logic              ap_ok;     // word-sized, upper address zero
  logic              perr_set, perr_clr;

  // ********************************
  // timing generator
  // ********************************
  stsr_tgen u_tgen (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ce       (ce),
    .in_vld   (tg_in),
    .in_rd    (cap_op_q == OP_READ),
    .in_addr  (cap_addr_q),
    .out_vld  (tg_vld),
    .out_rd   (tg_rd),
    .out_addr (tg_addr),
    .busy     (tg_busy)
  );

  // ********************************
  // memory pipeline
  // ********************************
  // hold is a synchronous enable, never a gated clock
  always_comb
  begin
    // basic waits for the next capture edge; advanced runs on
    fire  = (cap_op_q != OP_IDLE) && (adv_q || !mem_hold);
    b_ld  = fire && !adv_q && (cap_op_q inside {OP_READ, OP_DESEL});
    tg_in = fire && adv_q && (cap_op_q inside {OP_READ, OP_DESEL});
    // a mode switch with loads in flight lets basic win
    ld_vld  = b_ld || tg_vld;
    ld_rd   = b_ld ? (cap_op_q == OP_READ) : tg_rd;
    ld_addr = b_ld ? cap_addr_q : tg_addr;
    rd_word = mem_q[ld_addr];
    // capture stage
    cap_op_d   = cap_op_q;
    cap_addr_d = cap_addr_q;
    cap_wd_d   = cap_wd_q;
    if (!mem_hold)
    begin
      // every input registered, control included
      cap_addr_d = mem_addr;
      cap_wd_d   = mem_wdata;
      if (mem_sel)
        cap_op_d = mem_we ? OP_WRITE : OP_READ;
      else
        cap_op_d = mem_we ? OP_WSKIP : OP_DESEL;
    end
    else if (fire)
    begin
      // consumed with nothing new: held cycle does nothing
      cap_op_d = OP_IDLE;
    end
    // internal write strobe from the captured controls
    mem_d = mem_q;
    par_d = par_q;
    if (fire && cap_op_q == OP_WRITE)
    begin
      mem_d[cap_addr_q] = cap_wd_q;
      par_d[cap_addr_q] = stsr_par(cap_wd_q);
    end
    // output register moves only on a load event
    dout_d = dout_q;
    oe_d   = oe_q;
    if (ld_vld && ld_rd)
    begin
      dout_d = rd_word;
      oe_d   = 1'b1;
    end
    else if (ld_vld)
    begin
      // unselected read: deselect cycle
      oe_d = 1'b0;
    end
    // writes, selected or not, have no path into dout or oe
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cap_op_q   <= OP_IDLE;
      cap_addr_q <= '0;
      cap_wd_q   <= '0;
      dout_q     <= '0;
      oe_q       <= 1'b0;
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_q[i] <= '0;
        par_q[i] <= 1'b0;
      end
    end
    else if (ce)
    begin
      cap_op_q   <= cap_op_d;
      cap_addr_q <= cap_addr_d;
      cap_wd_q   <= cap_wd_d;
      mem_q      <= mem_d;
      par_q      <= par_d;
      dout_q     <= dout_d;
      oe_q       <= oe_d;
    end
  end

  // ********************************
  // register slave
  // ********************************
  // zero wait states, so the answer is always in the next cycle
  always_comb
  begin
    ap_ok    = (hsize == 3'h2) && (haddr[31:8] == 24'h000000);
    ap_take  = hsel && htrans[1] && hready;
    wpend_d  = ap_take && hwrite && ap_ok;
    wofs_d   = haddr[7:0];
    hrdata_d = 32'h00000000;
    if (ap_take && !hwrite && ap_ok)
    begin
      unique case (haddr[7:0])
        OFS_CTRL:
        begin
          hrdata_d[CTRL_ADV_BIT] = adv_q;
          hrdata_d[CTRL_PAR_BIT] = pen_q;
        end
        OFS_STAT:
        begin
          hrdata_d[STAT_OE_BIT]   = oe_q;
          hrdata_d[STAT_BUSY_BIT] = tg_busy;
          hrdata_d[STAT_PERR_BIT] = perr_q;
        end
        OFS_DOUT: hrdata_d[DATA_W-1:0] = dout_q;
        default:  hrdata_d = 32'h00000000; // unmapped reads zero
      endcase
    end
    adv_d = adv_q;
    pen_d = pen_q;
    if (wpend_q && wofs_q == OFS_CTRL)
    begin
      adv_d = hwdata[CTRL_ADV_BIT];
      pen_d = hwdata[CTRL_PAR_BIT];
    end
    // checker only observes; data path never looks at it
    perr_set = ld_vld && ld_rd && pen_q && (stsr_par(rd_word) != par_q[ld_addr]);
    perr_clr = wpend_q && wofs_q == OFS_STAT && hwdata[STAT_PERR_BIT];
    // set wins over clear
    perr_d = perr_set || (perr_q && !perr_clr);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wpend_q  <= 1'b0;
      wofs_q   <= 8'h00;
      hrdata_q <= 32'h00000000;
      hready_q <= 1'b1;
      adv_q    <= CTRL_ADV_RST;
      pen_q    <= CTRL_PAR_RST;
      perr_q   <= 1'b0;
    end
    else if (ce)
    begin
      wpend_q  <= wpend_d;
      wofs_q   <= wofs_d;
      hrdata_q <= hrdata_d;
      hready_q <= 1'b1;
      adv_q    <= adv_d;
      pen_q    <= pen_d;
      perr_q   <= perr_d;
    end
  end

  // outputs straight from flops, except hresp, which is tied low
  assign hreadyout   = hready_q;
  assign hresp       = 1'b0;
  assign hrdata      = hrdata_q;
  assign mem_dout    = dout_q;
  assign mem_dout_oe = oe_q;

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_wr_cap;
    ce && !mem_hold && mem_we && mem_sel;
  endsequence
  sequence s_adv_rd;
    ce && !mem_hold && adv_q && mem_sel && !mem_we ##1 ce && adv_q ##1 ce && adv_q;
  endsequence
  sequence s_basic_desel;
    ce && !mem_hold && !adv_q && !mem_we && !mem_sel ##1 ce && !mem_hold && !adv_q;
  endsequence

  chk_input_capture: assert property (
    ce && !mem_hold |=> cap_addr_q == $past(mem_addr) && cap_wd_q == $past(mem_wdata))
    else $error("inputs not captured");
  chk_write_internal: assert property (
    s_wr_cap ##1 ce && (adv_q || !mem_hold)
    |=> mem_q[$past(cap_addr_q)] == $past(cap_wd_q))
    else $error("captured write not stored");
  chk_basic_latency: assert property (
    ce && !mem_hold && !adv_q && cap_op_q == OP_READ
    |=> oe_q && dout_q == $past(rd_word))
    else $error("basic read not on next capture");
  chk_adv_timing: assert property (
    s_adv_rd |=> oe_q && $past(tg_addr) == $past(cap_addr_q, 2)
      && dout_q == $past(mem_q[tg_addr]))
    else $error("advanced read load late");
  chk_adv_no_wait: assert property (
    ce && mem_hold && tg_vld && tg_rd && !b_ld |=> oe_q && dout_q == $past(rd_word))
    else $error("advanced load waited for capture");
  chk_write_keeps: assert property (
    ce && fire && cap_op_q == OP_WRITE && !tg_vld |=> $stable(dout_q) && $stable(oe_q))
    else $error("write touched outputs");
  chk_hold_idle: assert property (
    ce && mem_hold && !fire && !tg_vld
    |=> $stable(cap_op_q) && $stable(cap_addr_q) && $stable(cap_wd_q) && $stable(dout_q))
    else $error("held cycle changed state");
  chk_gate_clean: assert property (
    !ce |=> $stable(dout_q) && $stable(oe_q) && $stable(cap_op_q) && $stable(adv_q))
    else $error("state moved while disabled");
  chk_dout_keep: assert property (
    !ld_vld |=> $stable(dout_q) && $stable(oe_q))
    else $error("outputs changed without load");
  chk_desel_off: assert property (
    s_basic_desel |=> !oe_q)
    else $error("deselect did not disable");
  chk_wskip_keep: assert property (
    ce && fire && cap_op_q == OP_WSKIP && oe_q && !tg_vld |=> oe_q)
    else $error("foreign write disabled outputs");
  chk_parity_quiet: assert property (
    ce && ld_vld && ld_rd |=> dout_q == $past(rd_word) && oe_q)
    else $error("parity logic disturbed read");
  chk_read_fetch: assert property (
    ce && b_ld && cap_op_q == OP_READ |=> dout_q == mem_q[$past(cap_addr_q)])
    else $error("read fetched wrong word");
endmodule
`default_nettype wire

// ---- tb/stsr_pipe_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ********************************
// pipeline logic at the memory port
// ********************************
module stsr_pipe_model
  import stsr_pkg::*;
(
  // clock shared with the memory
  input  wire logic              hclk,
  // request chosen by the bench
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic              req_we,
  input  wire logic              req_sel,
  input  wire logic              req_hold,
  // memory port
  output logic [ADDR_W-1:0]      mem_addr,
  output logic [DATA_W-1:0]      mem_wdata,
  output logic                   mem_we,
  output logic                   mem_sel,
  output logic                   mem_hold
);
  // start as a no-op so nothing is captured before the first request
  initial
  begin
    mem_addr  = 4'h0;
    mem_wdata = 16'h0;
    mem_we    = 1'b0;
    mem_sel   = 1'b0;
    mem_hold  = 1'b1;
  end

  // one cycle per clock, launched just after the edge
  always @(posedge hclk)
  begin
    mem_we   <= req_we;
    mem_sel  <= req_sel;
    mem_hold <= req_hold;
    // idle cycles carry a changing pattern, never stale values
    mem_addr  <= req_hold ? ~mem_addr : req_addr;
    mem_wdata <= req_hold ? ~mem_wdata : req_wdata;
  end
endmodule
`default_nettype wire

// ---- tb/stsr_core_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
// ********************************
// bench for the self-timed sram
// ********************************
module stsr_core_bench
  import stsr_pkg::*;
;
  // bus and clock
  logic              hclk, hresetn, ce, hwrite, hreadyout, hresp;
  logic [31:0]       haddr, hwdata, hrdata, rd, seed;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  // memory port
  logic [ADDR_W-1:0] req_addr, mem_addr, s1a;
  logic [DATA_W-1:0] req_wdata, mem_wdata, mem_dout, e_dout, s1d, s2d;
  logic              req_we, req_sel, req_hold, mem_we, mem_sel, mem_hold, mem_dout_oe;
  // reference model state
  logic [DATA_W-1:0] mem_m [DEPTH];
  logic              e_oe, s1v, s1we, s1sel, s2v, s2r, adv_m, cmp_on;
  int                num_errors, num_checks;

  stsr_core dut_u (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_sel(mem_sel), .mem_hold(mem_hold),
    .mem_dout(mem_dout), .mem_dout_oe(mem_dout_oe));

  stsr_pipe_model pipe_u (.hclk(hclk), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_we(req_we), .req_sel(req_sel), .req_hold(req_hold), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_sel(mem_sel), .mem_hold(mem_hold));

  // 50 mhz clock
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // ********************************
  // helpers
  // ********************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one single ahb-lite word transfer; no fixed latency assumed
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    logic r;
    logic rs;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'h2;
    do
    begin
      @(negedge hclk);
      r = hreadyout;
      @(posedge hclk);
    end
    while (r !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do
    begin
      @(negedge hclk);
      r  = hreadyout;
      rd = hrdata;
      rs = hresp;
      @(posedge hclk);
    end
    while (r !== 1'b1);
    // response must be okay on every transfer
    chk({31'h0, rs}, 32'h0);
  endtask

  // hand one cycle to the pipeline model
  task automatic put(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic w, input logic s, input logic h, input logic c);
    req_addr  <= a;
    req_wdata <= d;
    req_we    <= w;
    req_sel   <= s;
    req_hold  <= h;
    ce        <= c;
  endtask

  // random mix of reads, deselects, hidden writes, holds and gated clocks
  task automatic traffic(input int n);
    for (int i = 0; i < n; i++)
    begin
      repeat (8) seed = lfsr(seed);
      put(seed[3:0], seed[19:4], seed[20], seed[21] | seed[22], seed[24:23] == 2'h0,
          seed[27:25] != 3'h0);
      @(posedge hclk);
    end
    // drain with no-op cycles and the clock running
    put(4'h0, 16'h0, 1'b0, 1'b0, 1'b1, 1'b1);
    repeat (6) @(posedge hclk);
  endtask

  // status and output register against the model
  task automatic check_regs();
    bus(1'b0, OFS_STAT, 32'h0);
    chk({29'h0, rd[2:0]}, {31'h0, e_oe});
    bus(1'b0, OFS_DOUT, 32'h0);
    if (e_oe)
      chk(rd, {16'h0, e_dout});
  endtask

  // ********************************
  // reference model, one step per edge
  // ********************************
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      e_oe   = 1'b0;
      e_dout = 16'h0;
      s1v    = 1'b0;
      s2v    = 1'b0;
    end
    else if (ce)
    begin
      // advanced: execute the captured op, load the output one edge later
      if (adv_m)
      begin
        if (s2v) e_oe = s2r;
        if (s2v && s2r) e_dout = s2d;
        s2v = s1v && !s1we;
        s2r = s1sel;
        s2d = mem_m[s1a];
        if (s1v && s1we && s1sel) mem_m[s1a] = s1d;
        s1v = 1'b0;
      end
      // basic: the op executes at the next capture
      else if (!mem_hold && s1v)
      begin
        if (!s1we) e_oe = s1sel;
        if (!s1we && s1sel) e_dout = mem_m[s1a];
        if (s1we && s1sel) mem_m[s1a] = s1d;
      end
      if (!mem_hold)
      begin
        s1v   = 1'b1;
        s1we  = mem_we;
        s1sel = mem_sel;
        s1a   = mem_addr;
        s1d   = mem_wdata;
      end
    end
  end

  // outputs are compared every cycle, away from the edge
  always @(negedge hclk)
    if (cmp_on)
    begin
      chk({31'h0, mem_dout_oe}, {31'h0, e_oe});
      if (e_oe) chk({16'h0, mem_dout}, {16'h0, e_dout});
    end

  // ********************************
  // verdict and watchdog
  // ********************************
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // whole run is under 2000 cycles
  initial
  begin
    #100000;
    num_errors++;
    report_and_stop();
  end

  // ********************************
  // main sequence
  // ********************************
  initial
  begin
    hresetn = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'b00;
    hwrite  = 1'b0;
    hsize   = 3'h2;
    hwdata  = 32'h0;
    seed    = 32'h5460cd36;
    adv_m   = CTRL_ADV_RST;
    cmp_on  = 1'b0;
    put(4'h0, 16'h0, 1'b0, 1'b0, 1'b1, 1'b1);
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    cmp_on = 1'b1;
    @(posedge hclk);
    // reset values, unmapped place, parity check switched on
    bus(1'b0, OFS_CTRL, 32'h0);
    chk(rd, {30'h0, CTRL_PAR_RST, CTRL_ADV_RST});
    bus(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h3);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h3);
    $display("registers test done");
    // fill every word so later reads are defined
    for (int i = 0; i < DEPTH; i++)
    begin
      put(i[ADDR_W-1:0], 16'h5a00 ^ i[15:0], 1'b1, 1'b1, 1'b0, 1'b1);
      @(posedge hclk);
    end
    traffic(400);
    check_regs();
    $display("advanced mode test done");
    // basic mode: one period latency
    bus(1'b1, OFS_CTRL, 32'h0);
    // takes effect from the next edge, as the control register does
    adv_m <= 1'b0;
    bus(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    traffic(300);
    check_regs();
    $display("basic mode test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
